/* shared/plstrb_consts.svh */
// Constants for the PLL status readback register block.
// Overview of operation
// - Bit 6 shows VCO calibration finished.
// - Bit 5 follows holdover active, one clock late.
// - Bit 4 shows secondary reference selected.
// - Bit 3 shows VCO above monitor threshold.
// - Bit 2 shows secondary reference above threshold.
// - Bit 1 shows primary reference above threshold.
// - Bit 0 shows digital lock detect.
`ifndef PLSTRB_CONSTS_SVH
`define PLSTRB_CONSTS_SVH
`define PLSTRB_ADDR 10'h01F
`define PLSTRB_RESET 8'h00
`define PLSTRB_BIT_CAL 6
`define PLSTRB_BIT_HOLD 5
`define PLSTRB_BIT_REFSEL 4
`define PLSTRB_BIT_VCO 3
`define PLSTRB_BIT_SEC 2
`define PLSTRB_BIT_PRI 1
`define PLSTRB_BIT_LOCK 0
`define PLSTRB_BIT_RSVD 7
`endif

/* shared/plstrb_pkg.sv */
// Types for the PLL status readback register block.
package plstrb_pkg;
	typedef logic [7:0] plstrb_byte_t;
	typedef logic [9:0] plstrb_addr_t;
endpackage

/* shared/plstrb_flags_if.sv */
// Interface carrying the raw status flags between the block's modules.
`timescale 1ns/100ps
`default_nettype none
interface plstrb_flags_if;
	logic cal_done;
	logic holdover_active;
	logic secondary_selected;
	logic vco_above;
	logic secondary_above;
	logic primary_above;
	logic locked;
	modport src(output cal_done, holdover_active, secondary_selected, vco_above,
		secondary_above, primary_above, locked);
	modport dst(input cal_done, holdover_active, secondary_selected, vco_above,
		secondary_above, primary_above, locked);
endinterface
`default_nettype wire

/* src/plstrb_sampler.sv */
// Sampler that captures the status flags into the readback byte.
`timescale 1ns/100ps
`default_nettype none
`include "plstrb_consts.svh"
module plstrb_sampler (
	input wire logic clk_in,
	input wire logic rst_in,
	plstrb_flags_if.dst flags,
	output plstrb_pkg::plstrb_byte_t status_out
);
	plstrb_pkg::plstrb_byte_t status_r;
	plstrb_pkg::plstrb_byte_t status_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		status_nxt = `PLSTRB_RESET;
		status_nxt[`PLSTRB_BIT_CAL] = flags.cal_done;
		status_nxt[`PLSTRB_BIT_HOLD] = flags.holdover_active;
		status_nxt[`PLSTRB_BIT_REFSEL] = flags.secondary_selected;
		status_nxt[`PLSTRB_BIT_VCO] = flags.vco_above;
		status_nxt[`PLSTRB_BIT_SEC] = flags.secondary_above;
		status_nxt[`PLSTRB_BIT_PRI] = flags.primary_above;
		status_nxt[`PLSTRB_BIT_LOCK] = flags.locked;
		status_nxt[`PLSTRB_BIT_RSVD] = 1'b0;
	end

	// One register stage so a read sees a stable byte across the whole access.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			status_r <= `PLSTRB_RESET;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign status_out = status_r;

	////////////////////////////////////////////////////////////////////////
	a_flag_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		!rst_in |=> status_r[`PLSTRB_BIT_HOLD] == $past(flags.holdover_active))
		else $error("Holdover bit does not follow state.");
	a_lock_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(flags.locked) |=> status_r[`PLSTRB_BIT_LOCK])
		else $error("Lock bit missed rise.");
	a_cal_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		!rst_in |=> status_r[`PLSTRB_BIT_CAL] == $past(flags.cal_done))
		else $error("Calibration bit wrong.");
	a_refsel_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		!rst_in |=> status_r[`PLSTRB_BIT_REFSEL] == $past(flags.secondary_selected))
		else $error("Reference select bit wrong.");
	a_vco_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		!rst_in |=> status_r[`PLSTRB_BIT_VCO] == $past(flags.vco_above))
		else $error("VCO threshold bit wrong.");
	a_sec_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		!rst_in |=> status_r[`PLSTRB_BIT_SEC] == $past(flags.secondary_above))
		else $error("Secondary threshold bit wrong.");
	a_pri_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		!rst_in |=> status_r[`PLSTRB_BIT_PRI] == $past(flags.primary_above))
		else $error("Primary threshold bit wrong.");
	a_rsvd_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		status_r[`PLSTRB_BIT_RSVD] == 1'b0)
		else $error("Reserved bit nonzero.");
endmodule
`default_nettype wire

/* src/plstrb_top.sv */
// Top of the PLL status readback register block.
`timescale 1ns/100ps
`default_nettype none
`include "plstrb_consts.svh"
module plstrb_top (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CAL_DONE_IN,
	input wire logic HOLDOVER_ACTIVE_IN,
	input wire logic SECONDARY_SELECTED_IN,
	input wire logic VCO_ABOVE_IN,
	input wire logic SECONDARY_ABOVE_IN,
	input wire logic PRIMARY_ABOVE_IN,
	input wire logic LOCKED_IN,
	input wire logic [9:0] REG_ADDR_IN,
	input wire logic REG_RD_IN,
	input wire logic REG_WR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_HIT_OUT
);
	plstrb_flags_if flags_if ();
	plstrb_pkg::plstrb_byte_t status;
	plstrb_pkg::plstrb_byte_t rdata_r;

	function automatic logic addr_hit(input plstrb_pkg::plstrb_addr_t a);
		addr_hit = (a == `PLSTRB_ADDR);
	endfunction

	////////////////////////////////////////////////////////////////////////
	assign flags_if.cal_done = CAL_DONE_IN;
	assign flags_if.holdover_active = HOLDOVER_ACTIVE_IN;
	assign flags_if.secondary_selected = SECONDARY_SELECTED_IN;
	assign flags_if.vco_above = VCO_ABOVE_IN;
	assign flags_if.secondary_above = SECONDARY_ABOVE_IN;
	assign flags_if.primary_above = PRIMARY_ABOVE_IN;
	assign flags_if.locked = LOCKED_IN;

	plstrb_sampler u_sampler (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.flags(flags_if.dst),
		.status_out(status)
	);

	// Writes have no path into the status byte, so they cannot disturb it.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			rdata_r <= `PLSTRB_RESET;
		end else if (REG_RD_IN && addr_hit(REG_ADDR_IN)) begin
			rdata_r <= status;
		end else if (REG_RD_IN) begin
			rdata_r <= `PLSTRB_RESET;
		end
	end

	assign REG_RDATA_OUT = rdata_r;
	assign REG_HIT_OUT = (REG_RD_IN || REG_WR_IN) && addr_hit(REG_ADDR_IN);

	a_read_data: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN) |=> REG_RDATA_OUT == $past(status))
		else $error("Read data mismatch.");

	////////////////////////////////////////////////////////////////////////
	// A private copy of the pins, one edge late like the sampler, so the checks below
	// do not lean on the very register they guard.
	plstrb_pkg::plstrb_byte_t pins_d1_r;

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pins_d1_r <= `PLSTRB_RESET;
		end else begin
			pins_d1_r[`PLSTRB_BIT_RSVD] <= 1'b0;
			pins_d1_r[`PLSTRB_BIT_CAL] <= CAL_DONE_IN;
			pins_d1_r[`PLSTRB_BIT_HOLD] <= HOLDOVER_ACTIVE_IN;
			pins_d1_r[`PLSTRB_BIT_REFSEL] <= SECONDARY_SELECTED_IN;
			pins_d1_r[`PLSTRB_BIT_VCO] <= VCO_ABOVE_IN;
			pins_d1_r[`PLSTRB_BIT_SEC] <= SECONDARY_ABOVE_IN;
			pins_d1_r[`PLSTRB_BIT_PRI] <= PRIMARY_ABOVE_IN;
			pins_d1_r[`PLSTRB_BIT_LOCK] <= LOCKED_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_read_cal_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_CAL] == $past(pins_d1_r[`PLSTRB_BIT_CAL]))
		else $error("Read calibration bit wrong.");

	a_read_hold_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_HOLD] == $past(pins_d1_r[`PLSTRB_BIT_HOLD]))
		else $error("Read holdover bit wrong.");

	a_read_refsel_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_REFSEL] == $past(pins_d1_r[`PLSTRB_BIT_REFSEL]))
		else $error("Read reference select bit wrong.");

	a_read_vco_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_VCO] == $past(pins_d1_r[`PLSTRB_BIT_VCO]))
		else $error("Read VCO bit wrong.");

	a_read_sec_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_SEC] == $past(pins_d1_r[`PLSTRB_BIT_SEC]))
		else $error("Read secondary threshold bit wrong.");

	a_read_pri_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_PRI] == $past(pins_d1_r[`PLSTRB_BIT_PRI]))
		else $error("Read primary threshold bit wrong.");

	a_read_lock_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_LOCK] == $past(pins_d1_r[`PLSTRB_BIT_LOCK]))
		else $error("Read lock bit wrong.");

	a_read_rsvd_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT[`PLSTRB_BIT_RSVD] == 1'b0)
		else $error("Read reserved bit nonzero.");

	////////////////////////////////////////////////////////////////////////
	// Each flag must also drop out of the status byte, not only show up in it.
	a_cal_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(CAL_DONE_IN)
		|=> !status[`PLSTRB_BIT_CAL])
		else $error("Calibration bit stuck high.");

	a_hold_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(HOLDOVER_ACTIVE_IN)
		|=> !status[`PLSTRB_BIT_HOLD])
		else $error("Holdover bit stuck high.");

	a_refsel_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(SECONDARY_SELECTED_IN)
		|=> !status[`PLSTRB_BIT_REFSEL])
		else $error("Reference select bit stuck high.");

	a_vco_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(VCO_ABOVE_IN)
		|=> !status[`PLSTRB_BIT_VCO])
		else $error("VCO bit stuck high.");

	a_sec_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(SECONDARY_ABOVE_IN)
		|=> !status[`PLSTRB_BIT_SEC])
		else $error("Secondary threshold bit stuck high.");

	a_pri_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(PRIMARY_ABOVE_IN)
		|=> !status[`PLSTRB_BIT_PRI])
		else $error("Primary threshold bit stuck high.");

	a_lock_fall: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(LOCKED_IN)
		|=> !status[`PLSTRB_BIT_LOCK])
		else $error("Lock bit stuck high.");

	////////////////////////////////////////////////////////////////////////
	// Writes are accepted on the bus but have no route into any flop.
	a_write_no_status: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_WR_IN && addr_hit(REG_ADDR_IN)
		|=> status == pins_d1_r)
		else $error("Write disturbed status.");

	a_write_no_rdata: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_WR_IN && !REG_RD_IN
		|=> $stable(REG_RDATA_OUT))
		else $error("Write disturbed read data.");

	a_unmapped_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && !addr_hit(REG_ADDR_IN)
		|=> REG_RDATA_OUT == `PLSTRB_RESET)
		else $error("Unmapped read not zero.");

	a_rdata_stands: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!REG_RD_IN
		|=> $stable(REG_RDATA_OUT))
		else $error("Read data changed without read.");

	a_hit_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_RD_IN && (REG_ADDR_IN == `PLSTRB_ADDR)
		|-> REG_HIT_OUT)
		else $error("Read of status not flagged.");

	a_hit_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_WR_IN && (REG_ADDR_IN == `PLSTRB_ADDR)
		|-> REG_HIT_OUT)
		else $error("Write of status not flagged.");

	a_hit_other: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		REG_ADDR_IN != `PLSTRB_ADDR
		|-> !REG_HIT_OUT)
		else $error("Other address flagged.");

	a_hit_idle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!REG_RD_IN && !REG_WR_IN
		|-> !REG_HIT_OUT)
		else $error("Idle bus flagged.");

	a_reset_clear: assert property (@(posedge CLK_IN)
		RST_IN
		|=> REG_RDATA_OUT == `PLSTRB_RESET)
		else $error("Reset did not clear read data.");

	a_status_track: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!REG_WR_IN
		|-> status == pins_d1_r)
		else $error("Status does not track pins.");
endmodule
`default_nettype wire

/* verif/pll_status_readback_bench.sv */
// Self-checking bench for the PLL status readback register block.
`timescale 1ns/100ps
`default_nettype none
module pll_status_readback_bench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [6:0] flags = 7'h00;
	logic [6:0] f;
	logic [9:0] addr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] d;
	logic hit;
	integer err_count = 0;
	integer num_checks = 0;
	integer seed = 36;
	integer i;
	always #20 clk_in = ~clk_in;
	plstrb_top dut_u (.CLK_IN(clk_in), .RST_IN(rst_in), .CAL_DONE_IN(flags[6]),
		.HOLDOVER_ACTIVE_IN(flags[5]), .SECONDARY_SELECTED_IN(flags[4]),
		.VCO_ABOVE_IN(flags[3]), .SECONDARY_ABOVE_IN(flags[2]),
		.PRIMARY_ABOVE_IN(flags[1]), .LOCKED_IN(flags[0]), .REG_ADDR_IN(addr),
		.REG_RD_IN(rd), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.REG_HIT_OUT(hit));
	////////////////////////////////////////////////////////////////////////////////
	// The top bit is forced low because software may mask it as reserved.
	function automatic logic [7:0] expect_status(input logic [6:0] fl);
		return {1'b0, fl};
	endfunction
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t read data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t address hit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rd_reg(input logic [9:0] a, output logic [7:0] dv);
		@(negedge clk_in);
		addr = a;
		rd = 1'b1;
		#1 chk_bit(hit, a == 10'h01F);
		@(negedge clk_in);
		rd = 1'b0;
		dv = rdata;
	endtask
	task automatic wr_reg(input logic [9:0] a);
		@(negedge clk_in);
		addr = a;
		wr = 1'b1;
		wdata = 8'($random(seed));
		#1 chk_bit(hit, a == 10'h01F);
		@(negedge clk_in);
		wr = 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge clk_in);
		rst_in = 1'b0;
		rd_reg(10'h01F, d);
		chk_byte(d, expect_status(7'h00));
		// Walking one, all ones, then random flag sets, each with a write first.
		for (i = 0; i < 30; i++) begin
			f = (i < 7) ? 7'(1 << i) : (i == 7) ? 7'h7F : 7'($random(seed));
			@(negedge clk_in);
			flags = f;
			wr_reg(10'h01F);
			rd_reg(10'h01F, d);
			chk_byte(d, expect_status(f));
			rd_reg(10'h020 + 10'(i), d);
			chk_byte(d, 8'h00);
		end
		// Read data must stand between reads, and a second reset must clear it.
		rd_reg(10'h01F, d);
		repeat (2) @(negedge clk_in);
		chk_byte(rdata, d);
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk_byte(rdata, 8'h00);
		rst_in = 1'b0;
		rd_reg(10'h01F, d);
		chk_byte(d, expect_status(flags));
		tally_and_finish();
	end
endmodule
`default_nettype wire
